// ---- command_decoder.sv ----
// Command decoder for the on-chip flash array.
// Assumes write and read cycles come from CPU logic on clk, each strobe
// one cycle wide, and that the embedded program engine reports the end of
// an erase with a one-cycle pulse on the same clock.
//
// What this block does
// - Absolute write 0FFFFh from flash unlocks code protection
// - Absolute write 0FFFBh from flash restores code protection
// - Relock write ignored unless fetched from flash
// - Unlock and relock are single cycles, no preamble
// - xxF0h anywhere returns to array read
// - xxB0h pauses an ongoing sector wipe
// - xx30h while paused continues the wipe
// - Unlock, 80h, unlock, 30h at block starts wipe
// - Sixth cycle 10h starts whole-array wipe
// - Wrong cycle aborts sequence to array read
// - Query mode returns lock word at odd words
`include "flash_cmd_map.svh"

module command_decoder #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic wr_strobe,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_from_flash,
  input wire logic wr_absolute,
  input wire logic rd_strobe,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] lock_word_value,
  input wire logic engine_wipe_done,
  output logic code_temp_unlock_q,
  output logic word_write_q,
  output logic [ADDR_W-1:0] word_write_addr_q,
  output logic [DATA_W-1:0] word_write_data_q,
  output logic sector_wipe_q,
  output logic [ADDR_W-1:0] sector_wipe_addr_q,
  output logic chip_wipe_q,
  output logic pause_wipe_q,
  output logic continue_wipe_q,
  output logic set_block_code_lock_q,
  output logic [DATA_W-1:0] lock_word_data_q,
  output logic all_block_unlock_temp_q,
  output logic abort_q,
  output logic array_read_q,
  output logic lock_rd_valid_q,
  output logic [DATA_W-1:0] lock_rd_data_q
);

  // --------------------------------------------------------------------
  // Decode of the current write
  // --------------------------------------------------------------------
  flash_cmd_pkg::seq_state_t state_q;
  flash_cmd_pkg::seq_state_t state_d;
  logic wipe_run_q;
  logic wipe_paused_q;

  wire [`CODE_ADDR_W-1:0] code_addr = wr_addr[`CODE_ADDR_W-1:0];
  wire [7:0] cmd = wr_data[7:0];
  wire at_a = code_addr == `ADDR_CODE_A;
  wire at_b = code_addr == `ADDR_CODE_B;
  wire at_la = code_addr == `ADDR_LOCK_A;
  wire at_lb = code_addr == `ADDR_LOCK_B;
  wire odd_word = wr_addr[1:0] == `ODD_WORD_LSB;
  wire rd_odd_word = rd_addr[1:0] == `ODD_WORD_LSB;

  // Code lock words need an absolute write fetched from the array itself;
  // a write from any other memory is not taken as a lock command and goes on to the sequence tracker.
  wire code_src_ok = wr_from_flash & wr_absolute;
  wire is_unlock = wr_strobe & code_src_ok
                 & (wr_data == `WORD_CODE_UNLOCK);
  wire is_relock = wr_strobe & code_src_ok
                 & (wr_data == `WORD_CODE_RELOCK);
  wire code_word = wr_data == `WORD_CODE_UNLOCK
                 || wr_data == `WORD_CODE_RELOCK;

  wire is_return = wr_strobe & (cmd == `CMD_RETURN) & ~code_word;
  wire is_pause = wr_strobe & (cmd == `CMD_PAUSE) & wipe_run_q
                & ~wipe_paused_q;
  wire is_continue = wr_strobe & (cmd == `CMD_SECTOR) & wipe_paused_q
                   & (state_q == flash_cmd_pkg::ST_READ);
  wire single_cmd = is_unlock | is_relock | is_return | is_pause
                  | is_continue;
  wire seq_wr = wr_strobe & ~single_cmd;

  // --------------------------------------------------------------------
  // Sequence tracker
  // --------------------------------------------------------------------
  logic go_prog;
  logic go_sector;
  logic go_chip;
  logic go_lock;
  logic go_blk;
  logic bad;

  always_comb begin
    state_d = state_q;
    go_prog = 1'b0;
    go_sector = 1'b0;
    go_chip = 1'b0;
    go_lock = 1'b0;
    go_blk = 1'b0;
    bad = 1'b0;
    if (is_return) begin
      state_d = flash_cmd_pkg::ST_READ;
    end else if (is_pause) begin
      // A pause also closes the window for more block confirms, so the
      // next 30h is taken as a continue and not as another block.
      state_d = flash_cmd_pkg::ST_READ;
    end else if (seq_wr) begin
      unique case (state_q)
        flash_cmd_pkg::ST_READ,
        flash_cmd_pkg::ST_QUERY,
        flash_cmd_pkg::ST_WIPE_MORE: begin
          if (state_q == flash_cmd_pkg::ST_WIPE_MORE
              && cmd == `CMD_SECTOR) begin
            go_sector = 1'b1;
          end else if (cmd == `CMD_UNLOCK1 && at_a) begin
            state_d = flash_cmd_pkg::ST_STD1;
          end else if (cmd == `CMD_UNLOCK1 && at_la) begin
            state_d = flash_cmd_pkg::ST_LOCK1;
          end else begin
            state_d = flash_cmd_pkg::ST_READ;
            bad = state_q != flash_cmd_pkg::ST_READ;
          end
        end
        flash_cmd_pkg::ST_STD1: begin
          bad = !(cmd == `CMD_UNLOCK2 && at_b);
          state_d = bad ? flash_cmd_pkg::ST_READ : flash_cmd_pkg::ST_STD2;
        end
        flash_cmd_pkg::ST_STD2: begin
          if (cmd == `CMD_PROGRAM && at_a) begin
            state_d = flash_cmd_pkg::ST_PROG;
          end else if (cmd == `CMD_WIPE_EN && at_a && !wipe_run_q) begin
            state_d = flash_cmd_pkg::ST_WIPE1;
          end else begin
            state_d = flash_cmd_pkg::ST_READ;
            bad = 1'b1;
          end
        end
        flash_cmd_pkg::ST_PROG: begin
          go_prog = 1'b1;
          state_d = flash_cmd_pkg::ST_READ;
        end
        flash_cmd_pkg::ST_WIPE1: begin
          bad = !(cmd == `CMD_UNLOCK1 && at_a);
          state_d = bad ? flash_cmd_pkg::ST_READ : flash_cmd_pkg::ST_WIPE2;
        end
        flash_cmd_pkg::ST_WIPE2: begin
          bad = !(cmd == `CMD_UNLOCK2 && at_b);
          state_d = bad ? flash_cmd_pkg::ST_READ : flash_cmd_pkg::ST_WIPE3;
        end
        flash_cmd_pkg::ST_WIPE3: begin
          if (cmd == `CMD_CHIP && at_a) begin
            go_chip = 1'b1;
            state_d = flash_cmd_pkg::ST_READ;
          end else if (cmd == `CMD_SECTOR) begin
            go_sector = 1'b1;
            state_d = flash_cmd_pkg::ST_WIPE_MORE;
          end else begin
            state_d = flash_cmd_pkg::ST_READ;
            bad = 1'b1;
          end
        end
        flash_cmd_pkg::ST_LOCK1: begin
          bad = !(cmd == `CMD_UNLOCK2 && at_lb);
          state_d = bad ? flash_cmd_pkg::ST_READ : flash_cmd_pkg::ST_LOCK2;
        end
        flash_cmd_pkg::ST_LOCK2: begin
          if (cmd == `CMD_LOCK_SET && at_la) begin
            state_d = flash_cmd_pkg::ST_LOCK_WORD;
          end else if (cmd == `CMD_LOCK_QRY && at_la) begin
            state_d = flash_cmd_pkg::ST_QUERY;
          end else if (cmd == `CMD_BLK_TEMP && at_la) begin
            state_d = flash_cmd_pkg::ST_BLK_TEMP;
          end else begin
            state_d = flash_cmd_pkg::ST_READ;
            bad = 1'b1;
          end
        end
        flash_cmd_pkg::ST_LOCK_WORD: begin
          go_lock = odd_word;
          bad = !odd_word;
          state_d = flash_cmd_pkg::ST_READ;
        end
        flash_cmd_pkg::ST_BLK_TEMP: begin
          // The confirm is F0h, so only a wrong byte reaches this branch.
          state_d = flash_cmd_pkg::ST_READ;
          bad = 1'b1;
        end
        default: begin
          state_d = flash_cmd_pkg::ST_READ;
        end
      endcase
    end
  end

  wire blk_confirm = is_return
                   & (state_q == flash_cmd_pkg::ST_BLK_TEMP);
  wire wipe_start = go_sector | go_chip;
  wire wipe_end = engine_wipe_done | (is_return & wipe_paused_q);

  // --------------------------------------------------------------------
  // State and outputs
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= flash_cmd_pkg::ST_READ;
      wipe_run_q <= 1'b0;
      wipe_paused_q <= 1'b0;
      code_temp_unlock_q <= 1'b0;
      all_block_unlock_temp_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      // Unlock and relock never arrive together: their words differ.
      if (is_unlock) begin
        code_temp_unlock_q <= 1'b1;
      end else if (is_relock) begin
        code_temp_unlock_q <= 1'b0;
      end
      if (blk_confirm) begin
        all_block_unlock_temp_q <= 1'b1;
      end
      if (wipe_start) begin
        wipe_run_q <= 1'b1;
      end else if (wipe_end) begin
        wipe_run_q <= 1'b0;
      end
      if (is_pause) begin
        wipe_paused_q <= 1'b1;
      end else if (is_continue | wipe_end) begin
        wipe_paused_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_write_q <= 1'b0;
      sector_wipe_q <= 1'b0;
      chip_wipe_q <= 1'b0;
      pause_wipe_q <= 1'b0;
      continue_wipe_q <= 1'b0;
      set_block_code_lock_q <= 1'b0;
      abort_q <= 1'b0;
    end else if (clk_en) begin
      word_write_q <= go_prog;
      sector_wipe_q <= go_sector;
      chip_wipe_q <= go_chip;
      pause_wipe_q <= is_pause;
      continue_wipe_q <= is_continue;
      set_block_code_lock_q <= go_lock;
      abort_q <= bad | (is_return & wipe_paused_q);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_write_addr_q <= '0;
      word_write_data_q <= '0;
      sector_wipe_addr_q <= '0;
      lock_word_data_q <= '0;
    end else if (clk_en) begin
      if (go_prog) begin
        word_write_addr_q <= wr_addr;
        word_write_data_q <= wr_data;
      end
      if (go_sector) begin
        sector_wipe_addr_q <= wr_addr;
      end
      if (go_lock) begin
        lock_word_data_q <= wr_data;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  // A read answers one cycle after its strobe; array_read_q tells the
  // array mux whether the plain array or the lock word is to be shown.
  wire query_hit = rd_strobe & rd_odd_word
                 & (state_q == flash_cmd_pkg::ST_QUERY);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      array_read_q <= 1'b1;
      lock_rd_valid_q <= 1'b0;
      lock_rd_data_q <= '0;
    end else if (clk_en) begin
      array_read_q <= state_d == flash_cmd_pkg::ST_READ;
      lock_rd_valid_q <= query_hit;
      if (query_hit) begin
        lock_rd_data_q <= lock_word_value;
      end
    end
  end

endmodule : command_decoder

// ---- command_decoder_props.sv ----
// Assertions on the ports of the flash command decoder.
// Assumes one clock domain and nrst active low.
`include "flash_cmd_map.svh"
module command_decoder_props #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic wr_strobe,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_from_flash,
  input wire logic wr_absolute,
  input wire logic rd_strobe,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] lock_word_value,
  input wire logic code_temp_unlock_q,
  input wire logic word_write_q,
  input wire logic [DATA_W-1:0] word_write_data_q,
  input wire logic sector_wipe_q,
  input wire logic chip_wipe_q,
  input wire logic pause_wipe_q,
  input wire logic continue_wipe_q,
  input wire logic set_block_code_lock_q,
  input wire logic [DATA_W-1:0] lock_word_data_q,
  input wire logic abort_q,
  input wire logic array_read_q,
  input wire logic lock_rd_valid_q,
  input wire logic [DATA_W-1:0] lock_rd_data_q
);
  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (!nrst);
  wire logic wv = clk_en && wr_strobe;
  wire logic [7:0] cb = wr_data[7:0];
  wire logic [13:0] ca = wr_addr[13:0];
  wire logic code_ok = wv && wr_from_flash && wr_absolute;
  wire logic word_cmd = wr_data[7:0] == 8'hff || wr_data[7:0] == 8'hfb;
  wire logic odd_wr = wr_addr[1:0] == `ODD_WORD_LSB;
  wire logic odd_rd = rd_strobe && rd_addr[1:0] == `ODD_WORD_LSB;
  // Only the gap inside s_std is pinned; the ##2 gaps of s_prog leave a cycle where a stray write can slip in.
  sequence s_std;
    wv && cb == `CMD_UNLOCK1 && ca == `ADDR_CODE_A && array_read_q
    ##1 !wr_strobe ##1 wv && cb == `CMD_UNLOCK2 && ca == `ADDR_CODE_B;
  endsequence
  sequence s_prog;
    s_std ##2 wv && cb == `CMD_PROGRAM && ca == `ADDR_CODE_A ##2 wv;
  endsequence
  a_unlock_sets: assert property (
    code_ok && wr_data == `WORD_CODE_UNLOCK |=> code_temp_unlock_q
  ) else $error("unlock write did not lift protection");
  a_relock_clears: assert property (
    code_ok && wr_data == `WORD_CODE_RELOCK |=> !code_temp_unlock_q
  ) else $error("relock write did not restore protection");
  a_ram_ignored: assert property (
    wv && !wr_from_flash |=> $stable(code_temp_unlock_q)
  ) else $error("write from outside flash changed protection");
  a_single_cycle: assert property (
    !code_ok |=> $stable(code_temp_unlock_q)
  ) else $error("protection changed without a code write");
  a_return_read: assert property (
    wv && cb == `CMD_RETURN && !word_cmd
    |=> array_read_q || word_write_q || set_block_code_lock_q
  ) else $error("return command did not reach array read");
  a_pause_cause: assert property (
    pause_wipe_q |-> $past(wv) && $past(cb) == `CMD_PAUSE
  ) else $error("pause without its command");
  a_continue_cause: assert property (
    continue_wipe_q |-> $past(cb) == `CMD_SECTOR && !sector_wipe_q
  ) else $error("continue without its command");
  a_sector_cause: assert property (
    sector_wipe_q |-> $past(wv) && $past(cb) == `CMD_SECTOR
  ) else $error("sector wipe without confirm");
  a_chip_cause: assert property (
    chip_wipe_q |-> $past(cb) == `CMD_CHIP && $past(ca) == `ADDR_CODE_A
  ) else $error("chip wipe without its sixth cycle");
  a_abort_read: assert property (
    abort_q |-> array_read_q
  ) else $error("abort left decoder out of array read");
  a_lock_read: assert property (
    lock_rd_valid_q |-> $past(odd_rd)
    && lock_rd_data_q == $past(lock_word_value)
  ) else $error("lock word read wrong");
  a_prog_start: assert property (
    s_prog |=> word_write_q && word_write_data_q == $past(wr_data)
  ) else $error("program sequence gave no word write");
  a_lock_word: assert property (
    set_block_code_lock_q |-> $past(odd_wr)
    && lock_word_data_q == $past(wr_data)
  ) else $error("lock word write wrong");
endmodule : command_decoder_props

bind command_decoder command_decoder_props #(
  .ADDR_W(ADDR_W),
  .DATA_W(DATA_W)
) props_i (.*);

// ---- cpu_bus_model.sv ----
// CPU side: issues flash write and read cycles, one strobe cycle each.
// Assumes the decoder samples on the rising edge of clk.
module cpu_bus_model (
  input wire logic clk,
  output logic wr_strobe,
  output logic [17:0] wr_addr,
  output logic [15:0] wr_data,
  output logic wr_from_flash,
  output logic wr_absolute,
  output logic rd_strobe,
  output logic [17:0] rd_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wr_strobe, wr_addr, wr_data, wr_from_flash, wr_absolute} = '0;
    {rd_strobe, rd_addr} = '0;
  end
  task automatic wr(input logic [17:0] a, input logic [15:0] d,
                    input logic f, input logic ab);
    @(posedge clk);
    #1;
    wr_strobe = 1'b1;
    wr_addr = a;
    wr_data = d;
    wr_from_flash = f;
    wr_absolute = ab;
    @(posedge clk);
    #1;
    wr_strobe = 1'b0;
    // A released bus shows junk on data and address, never their last value.
    wr_data = ~d;
    wr_addr = ~a;
  endtask : wr
  task automatic rd(input logic [17:0] a);
    @(posedge clk);
    #1;
    rd_strobe = 1'b1;
    rd_addr = a;
    @(posedge clk);
    #1;
    rd_strobe = 1'b0;
    rd_addr = ~a;
  endtask : rd
endmodule : cpu_bus_model

// ---- flash_cmd_map.svh ----
// Constants of the flash command decoder: coded addresses and command bytes.
// Assumes byte addresses from the CPU with A14 and above ignored for codes.
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH

// ----------------------------------------------------------------------
// Coded addresses, compared on the low bits only
// ----------------------------------------------------------------------
`define CODE_ADDR_W 14
`define ADDR_CODE_A 14'h1554
`define ADDR_CODE_B 14'h2aa8
`define ADDR_LOCK_A 14'h2a54
`define ADDR_LOCK_B 14'h15a8
`define ODD_WORD_LSB 2'h2

// ----------------------------------------------------------------------
// Command bytes, low byte of the written word
// ----------------------------------------------------------------------
`define CMD_UNLOCK1 8'ha8
`define CMD_UNLOCK2 8'h54
`define CMD_RETURN 8'hf0
`define CMD_PROGRAM 8'ha0
`define CMD_WIPE_EN 8'h80
`define CMD_SECTOR 8'h30
`define CMD_CHIP 8'h10
`define CMD_PAUSE 8'hb0
`define CMD_LOCK_SET 8'hc0
`define CMD_LOCK_QRY 8'h90
`define CMD_BLK_TEMP 8'hc1

// ----------------------------------------------------------------------
// Whole-word code lock commands
// ----------------------------------------------------------------------
`define WORD_CODE_UNLOCK 16'hffff
`define WORD_CODE_RELOCK 16'hfffb

`endif

// ---- flash_cmd_pkg.sv ----
// Types shared by the flash command decoder.
// Assumes nothing of its surroundings.
package flash_cmd_pkg;

  // --------------------------------------------------------------------
  // Sequence states
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_READ,
    ST_STD1,
    ST_STD2,
    ST_PROG,
    ST_WIPE1,
    ST_WIPE2,
    ST_WIPE3,
    ST_WIPE_MORE,
    ST_LOCK1,
    ST_LOCK2,
    ST_LOCK_WORD,
    ST_QUERY,
    ST_BLK_TEMP
  } seq_state_t;

endpackage : flash_cmd_pkg

// ---- test_command_decoder.sv ----
// Self-checking bench for the flash command decoder.
// Assumes the CPU model drives all write and read cycles.
`include "flash_cmd_map.svh"
module test_command_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, clk_en, engine_wipe_done;
  logic [15:0] lock_word_value;
  logic wr_strobe, wr_from_flash, wr_absolute, rd_strobe;
  logic [17:0] wr_addr, rd_addr, word_write_addr_q, sector_wipe_addr_q;
  logic [15:0] wr_data, word_write_data_q, lock_word_data_q, lock_rd_data_q;
  logic code_temp_unlock_q, word_write_q, sector_wipe_q, chip_wipe_q;
  logic pause_wipe_q, continue_wipe_q, set_block_code_lock_q, abort_q;
  logic all_block_unlock_temp_q, array_read_q, lock_rd_valid_q;
  int bad_count = 0;
  int checked = 0;
  command_decoder DUT (.*);
  cpu_bus_model cpu (.*);
  // ------------------------------------------------------------------
  // Checks and shorthands
  // ------------------------------------------------------------------
  task automatic cf(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: flag %b not %b", $time, g, e);
    end
  endtask : cf
  task automatic cw(input logic [17:0] g, input logic [17:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: word %h not %h", $time, g, e);
    end
  endtask : cw
  task automatic w(input logic [17:0] a, input logic [15:0] d);
    cpu.wr(a, d, 1'b0, 1'b0);
  endtask : w
  task automatic std();
    w(`ADDR_CODE_A, `CMD_UNLOCK1);
    w(`ADDR_CODE_B, `CMD_UNLOCK2);
  endtask : std
  task automatic wipe_en();
    std();
    w(`ADDR_CODE_A, `CMD_WIPE_EN);
    std();
  endtask : wipe_en
  task automatic done_pulse();
    @(posedge clk);
    #1 engine_wipe_done = 1'b1;
    @(posedge clk);
    #1 engine_wipe_done = 1'b0;
  endtask : done_pulse
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_code_lock();
    cpu.wr(18'h30010, `WORD_CODE_UNLOCK, 1'b0, 1'b1);
    cf(code_temp_unlock_q, 1'b0);
    cpu.wr(18'h30010, `WORD_CODE_UNLOCK, 1'b1, 1'b1);
    cf(code_temp_unlock_q, 1'b1);
    cpu.wr(18'h04002, `WORD_CODE_RELOCK, 1'b0, 1'b1);
    cf(code_temp_unlock_q, 1'b1);
    cpu.wr(18'h04002, `WORD_CODE_RELOCK, 1'b1, 1'b1);
    cf(code_temp_unlock_q, 1'b0);
    // With the clock enable low the unlock word must leave no trace.
    clk_en = 1'b0;
    cpu.wr(18'h30010, `WORD_CODE_UNLOCK, 1'b1, 1'b1);
    cf(code_temp_unlock_q, 1'b0);
    clk_en = 1'b1;
  endtask : t_code_lock
  task automatic t_prog();
    std();
    w(`ADDR_CODE_A, `CMD_PROGRAM);
    w(18'h20246, 16'hbeef);
    cf(word_write_q, 1'b1);
    cw(word_write_addr_q, 18'h20246);
    cw(word_write_data_q, 16'hbeef);
    w(`ADDR_CODE_A, `CMD_UNLOCK1);
    w(18'h00100, `CMD_UNLOCK2);
    cf(abort_q, 1'b1);
    cf(array_read_q, 1'b1);
    w(`ADDR_CODE_A, `CMD_UNLOCK1);
    cf(array_read_q, 1'b0);
    w(18'h0, `CMD_RETURN);
    cf(array_read_q, 1'b1);
  endtask : t_prog
  task automatic t_wipe();
    wipe_en();
    w(18'h18000, `CMD_SECTOR);
    cf(sector_wipe_q, 1'b1);
    cw(sector_wipe_addr_q, 18'h18000);
    w(18'h0, `CMD_PAUSE);
    cf(pause_wipe_q, 1'b1);
    w(18'h0, `CMD_SECTOR);
    cf(continue_wipe_q, 1'b1);
    done_pulse();
    w(18'h0, `CMD_PAUSE);
    cf(pause_wipe_q, 1'b0);
    wipe_en();
    w(`ADDR_CODE_A, `CMD_CHIP);
    cf(chip_wipe_q, 1'b1);
    done_pulse();
  endtask : t_wipe
  task automatic t_lock();
    w(`ADDR_LOCK_A, `CMD_UNLOCK1);
    w(`ADDR_LOCK_B, `CMD_UNLOCK2);
    w(`ADDR_LOCK_A, `CMD_LOCK_SET);
    w(18'h00006, 16'h7ffe);
    cf(set_block_code_lock_q, 1'b1);
    cw(lock_word_data_q, 16'h7ffe);
    w(`ADDR_LOCK_A, `CMD_UNLOCK1);
    w(`ADDR_LOCK_B, `CMD_UNLOCK2);
    w(`ADDR_LOCK_A, `CMD_LOCK_QRY);
    cpu.rd(18'h00004);
    cf(lock_rd_valid_q, 1'b0);
    cpu.rd(18'h0000a);
    cf(lock_rd_valid_q, 1'b1);
    cw(lock_rd_data_q, 16'h5a3c);
    w(18'h0, `CMD_RETURN);
    cf(array_read_q, 1'b1);
    cf(all_block_unlock_temp_q, 1'b0);
    w(`ADDR_LOCK_A, `CMD_UNLOCK1);
    w(`ADDR_LOCK_B, `CMD_UNLOCK2);
    w(`ADDR_LOCK_A, `CMD_BLK_TEMP);
    w(18'h0, `CMD_RETURN);
    cf(all_block_unlock_temp_q, 1'b1);
  endtask : t_lock
  task automatic tally_and_finish();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    engine_wipe_done = 1'b0;
    lock_word_value = 16'h5a3c;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    t_code_lock();
    t_prog();
    t_wipe();
    t_lock();
    tally_and_finish();
  end
endmodule : test_command_decoder
